// *** sleep_wake_reset_control.sv ***
// Reset, sleep and wake-up sequencer with AHB-Lite register access
//
// Summary of operation
// - On entering sleep the levels of port bits 0 to 3 are captured as wake references.
// - While asleep a filtered level different from its reference causes a warm reset.
// - A pin-change wake clears the pin-change wake flag so software can see the cause.
// - Port bit 7 also wakes the device, sharing the wake enable and flag.
// - With brown-out detection active, a low supply holds the core in reset while it lasts.
// - Brown-out detection is off at power-up and turns on when software writes zero to its bit.
// - The watchdog runs whenever its configuration fuse is programmed to enable, except in sleep, where the value latched at entry rules.
// - On sleep entry the watchdog enable is latched and held until wake.
// - With the fuse clear, option bit 4 switches the watchdog on and off.
// - The software watchdog enable is clear after power-up.
// - With RC oscillator selected the start-up delay is 1.0 ms instead of 18 ms.
// - The short RC delay applies after every reset cause.
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_reset_control
   import sleep_wake_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [7:0]  high_voltage_port,
   input  wire logic        external_reset_pin_n,
   input  wire logic        supply_low,
   input  wire logic        wdt_fuse,
   input  wire logic        osc_select_high,
   input  wire logic        osc_select_low,
   input  wire logic        wdt_timeout,
   output logic             core_reset_n,
   output logic             wdt_enable,
   output logic             sleeping
);
   ////////////////////////////////////////////////////////////////////////////
   // Wake input filters
   logic [4:0] wake_in;
   logic [4:0] wake_filt;
   assign wake_in = {high_voltage_port[WAKE_HI_PIN], high_voltage_port[3:0]};

   for (genvar i = 0; i < 5; i++)
   begin : g_filt
      glitch_filter u_filt
      (
         .hclk    (hclk),
         .hresetn (hresetn),
         .din     (wake_in[i]),
         .dout    (wake_filt[i])
      );
   end

   function automatic logic [CNT_W-1:0] start_cycles(input logic [1:0] osc);
      start_cycles = (osc == OSC_RC) ? CNT_W'(RC_START_CYC)
                                     : CNT_W'(STD_START_CYC);
   endfunction : start_cycles

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite address phase capture
   logic        wr_pend_reg;
   logic        wr_pend_next;
   logic [11:0] addr_reg;
   logic [11:0] addr_next;
   logic        acc;
   assign acc = hsel & hready & htrans[1];

   always_comb
   begin
      wr_pend_next = acc & hwrite;
      addr_next    = acc ? haddr : addr_reg;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer and registers
   seq_state_e       state_reg;
   seq_state_e       state_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic [7:0]       opt_reg;
   logic [7:0]       opt_next;
   logic             flag_reg;
   logic             flag_next;
   logic [4:0]       ref_reg;
   logic [4:0]       ref_next;
   logic             wdt_latch_reg;
   logic             wdt_latch_next;
   logic             lvd_on_reg;
   logic             lvd_on_next;
   logic [31:0]      rdata_reg;
   logic [31:0]      rdata_next;
   logic             hold_rst;
   logic             pin_wake;
   logic             wdt_live;

   // Brown-out acts like the reset pin while detection is on
   assign hold_rst = ~external_reset_pin_n | (lvd_on_reg & supply_low);
   assign pin_wake = opt_reg[BIT_WAKE_EN] & |(wake_filt ^ ref_reg);
   assign wdt_live = wdt_fuse | opt_reg[BIT_SW_WDT_EN];

   always_comb
   begin
      state_next     = state_reg;
      cnt_next       = cnt_reg;
      opt_next       = opt_reg;
      flag_next      = flag_reg;
      ref_next       = ref_reg;
      wdt_latch_next = wdt_latch_reg;
      lvd_on_next    = lvd_on_reg;
      rdata_next     = '0;

      if (wr_pend_reg)
      begin
         case (addr_reg)
            OFS_SECONDARY_OPTION_REGISTER:
            begin
               opt_next    = hwdata[7:0];
               lvd_on_next = ~hwdata[BIT_LVD_EN_N];
            end
            OFS_CONTROL:
            begin
               if (hwdata[BIT_FLAG_SET])
                  flag_next = 1'b1;
               if (hwdata[BIT_SLEEP_REQ] && state_reg == ST_RUN)
               begin
                  state_next     = ST_SLEEP;
                  ref_next       = wake_filt;
                  wdt_latch_next = wdt_live;
               end
            end
            default:
            begin
            end
         endcase
      end

      case (state_reg)
         ST_HOLD:
         begin
            cnt_next = start_cycles({osc_select_high, osc_select_low});
            if (!hold_rst)
               state_next = ST_START;
         end
         ST_START:
         begin
            if (cnt_reg > CNT_W'(1))
               cnt_next = cnt_reg - CNT_W'(1);
            else
               state_next = ST_RUN;
         end
         ST_RUN:
         begin
            if (wdt_live && wdt_timeout)
               state_next = ST_HOLD;
         end
         ST_SLEEP:
         begin
            // Hardware clear beats any software set in the same cycle
            if (pin_wake)
            begin
               flag_next  = 1'b0;
               state_next = ST_HOLD;
            end
            else if (wdt_latch_reg && wdt_timeout)
               state_next = ST_HOLD;
         end
         default:
            state_next = ST_HOLD;
      endcase

      if (hold_rst)
         state_next = ST_HOLD;

      case (addr_next)
         OFS_SECONDARY_OPTION_REGISTER: rdata_next = {24'h0, opt_next};
         OFS_STATUS:  rdata_next = {28'h0, state_next == ST_SLEEP, state_next != ST_RUN,
                                    wdt_enable_val(state_next, wdt_latch_next, wdt_live), flag_next};
         default:     rdata_next = '0;
      endcase
   end

   function automatic logic wdt_enable_val(input seq_state_e st, input logic lat, input logic live);
      wdt_enable_val = (st == ST_SLEEP) ? lat : live;
   endfunction : wdt_enable_val

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_reg     <= ST_HOLD;
         cnt_reg       <= '0;
         opt_reg       <= SECONDARY_OPTION_REGISTER_RESET;
         flag_reg      <= 1'b1;
         ref_reg       <= '0;
         wdt_latch_reg <= 1'b0;
         lvd_on_reg    <= 1'b0;
         wr_pend_reg   <= 1'b0;
         addr_reg      <= '0;
         rdata_reg     <= '0;
      end
      else
      begin
         state_reg     <= state_next;
         cnt_reg       <= cnt_next;
         opt_reg       <= opt_next;
         flag_reg      <= flag_next;
         ref_reg       <= ref_next;
         wdt_latch_reg <= wdt_latch_next;
         lvd_on_reg    <= lvd_on_next;
         wr_pend_reg   <= wr_pend_next;
         addr_reg      <= addr_next;
         rdata_reg     <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs from flip-flops
   logic out_rst_n_reg;
   logic out_wdt_reg;
   logic out_sleep_reg;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         out_rst_n_reg <= 1'b0;
         out_wdt_reg   <= 1'b0;
         out_sleep_reg <= 1'b0;
      end
      else
      begin
         out_rst_n_reg <= (state_next == ST_RUN) || (state_next == ST_SLEEP);
         out_wdt_reg   <= wdt_enable_val(state_next, wdt_latch_next, wdt_live);
         out_sleep_reg <= state_next == ST_SLEEP;
      end
   end

   assign core_reset_n = out_rst_n_reg;
   assign wdt_enable   = out_wdt_reg;
   assign sleeping     = out_sleep_reg;
   assign hrdata       = rdata_reg;
   assign hreadyout    = 1'b1;
   assign hresp        = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_brownout_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      (lvd_on_reg && supply_low) |=> !core_reset_n)
      else $error("core released during brown-out");
   a_lvd_off_reset: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(hresetn) |-> !lvd_on_reg)
      else $error("brown-out detect on after reset");
   a_fuse_wdt_run: assert property (@(posedge hclk) disable iff (!hresetn)
      (wdt_fuse && state_reg != ST_SLEEP && state_next != ST_SLEEP) |=> wdt_enable)
      else $error("watchdog off with fuse set");
   a_sw_wdt_ctl: assert property (@(posedge hclk) disable iff (!hresetn)
      (!wdt_fuse && state_next == ST_RUN) |=> wdt_enable == $past(opt_reg[BIT_SW_WDT_EN]))
      else $error("software watchdog enable not followed");
   a_wake_flag: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_reg == ST_SLEEP && pin_wake && !hold_rst) |=> (!flag_reg && state_reg == ST_HOLD))
      else $error("pin wake did not clear flag");
   a_ref_capture: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_reg == ST_RUN && state_next == ST_SLEEP) |=> ref_reg == $past(wake_filt))
      else $error("wake reference not captured");
   a_wake_exit: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_reg == ST_SLEEP && pin_wake) |=> state_reg == ST_HOLD ##1 !core_reset_n)
      else $error("pin change did not wake");
   a_wdt_latched: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_reg == ST_SLEEP && state_next == ST_SLEEP) |=> wdt_enable == wdt_latch_reg)
      else $error("watchdog setting changed in sleep");
   a_start_delay: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_reg == ST_HOLD && !hold_rst) |=> (cnt_reg == start_cycles($past({osc_select_high,
         osc_select_low}))))
      else $error("start delay count wrong");
endmodule : sleep_wake_reset_control
`default_nettype wire

// *** sleep_wake_pkg.sv ***
// Constants for the sleep, wake and reset control block
package sleep_wake_pkg;
   // Time figures in their own units
   localparam int unsigned CLK_HZ         = 40_000_000;
   localparam int unsigned RC_START_US    = 1000;   // 1.0 ms
   localparam int unsigned STD_START_US   = 18000;  // 18 ms
   localparam int unsigned GLITCH_NS      = 100;
   localparam int unsigned CLK_NS         = 25;
   // Derived cycle counts
   localparam int unsigned RC_START_CYC   = (RC_START_US / 1000) * (CLK_HZ / 1000);
   localparam int unsigned STD_START_CYC  = (STD_START_US / 1000) * (CLK_HZ / 1000);
   localparam int unsigned GLITCH_CYC     = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
   localparam int          CNT_W          = 20;
   localparam int          FLT_W          = 4;

   // Register map
   localparam logic [11:0] OFS_SECONDARY_OPTION_REGISTER    = 12'h000;
   localparam logic [11:0] OFS_STATUS     = 12'h004;
   localparam logic [11:0] OFS_CONTROL    = 12'h008;

   // Secondary option register fields
   localparam int          BIT_WAKE_EN    = 0;
   localparam int          BIT_LVD_EN_N   = 1;
   localparam int          BIT_SW_WDT_EN  = 4;
   localparam logic [7:0]  SECONDARY_OPTION_REGISTER_RESET  = 8'h02;

   // Status register fields
   localparam int          BIT_PCW_FLAG   = 0;
   localparam int          BIT_WDT_RUN    = 1;
   localparam int          BIT_CORE_RST   = 2;
   localparam int          BIT_ASLEEP     = 3;

   // Control register fields
   localparam int          BIT_SLEEP_REQ  = 0;
   localparam int          BIT_FLAG_SET   = 1;

   // Wake pin positions on the high-voltage port
   localparam int          WAKE_HI_PIN    = 7;

   // Oscillator select code for RC
   localparam logic [1:0]  OSC_RC         = 2'b11;

   typedef enum logic [1:0]
   {
      ST_HOLD  = 2'b00,
      ST_START = 2'b01,
      ST_RUN   = 2'b10,
      ST_SLEEP = 2'b11
   } seq_state_e;
endpackage : sleep_wake_pkg

// *** glitch_filter.sv ***
// Glitch filter for one wake input
`timescale 1ns/1ps
`default_nettype none
module glitch_filter
   import sleep_wake_pkg::*;
(
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic din,
   output logic      dout
);
   logic             dout_reg;
   logic             dout_next;
   logic [FLT_W-1:0] cnt_reg;
   logic [FLT_W-1:0] cnt_next;

   // A change must persist for a full filter window before it shows
   always_comb
   begin
      dout_next = dout_reg;
      cnt_next  = '0;
      if (din != dout_reg)
      begin
         if (cnt_reg == FLT_W'(GLITCH_CYC - 1))
            dout_next = din;
         else
            cnt_next = cnt_reg + FLT_W'(1);
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dout_reg <= 1'b0;
         cnt_reg  <= '0;
      end
      else
      begin
         dout_reg <= dout_next;
         cnt_reg  <= cnt_next;
      end
   end

   assign dout = dout_reg;
endmodule : glitch_filter
`default_nettype wire

// *** external_pins.sv ***
// Model of the board pins around the sleep, wake and reset block
`timescale 1ns/1ps
`default_nettype none
module external_pins
(
   input  wire logic  hclk,
   output logic [7:0] high_voltage_port,
   output logic       external_reset_pin_n,
   output logic       supply_low,
   output logic       wdt_fuse,
   output logic       osc_select_high,
   output logic       osc_select_low,
   output logic       wdt_timeout
);
   // RC oscillator for the whole run: the 18 ms path would exceed the run length
   initial
   begin
      high_voltage_port = 8'h00;
      external_reset_pin_n = 1'b1;
      supply_low = 1'b0;
      wdt_fuse = 1'b0;
      osc_select_high = 1'b1;
      osc_select_low = 1'b1;
      wdt_timeout = 1'b0;
   end

   task automatic set_port(input logic [7:0] v);
      @(posedge hclk);
      high_voltage_port <= v;
   endtask : set_port

   task automatic set_ctl(input logic sup, input logic fuse);
      @(posedge hclk);
      supply_low <= sup;
      wdt_fuse   <= fuse;
   endtask : set_ctl

   // Timeout pulse from the watchdog counter outside the block
   task automatic set_wdt(input logic v);
      @(posedge hclk);
      wdt_timeout <= v;
   endtask : set_wdt
endmodule : external_pins
`default_nettype wire

// *** testbench.sv ***
// Self-checking testbench for the sleep, wake and reset block
`timescale 1ns/1ps
`default_nettype none
module testbench
   import sleep_wake_pkg::*;
;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic        core_reset_n, wdt_enable, sleeping;
   logic        ext_n, sup, fuse, osch, oscl, wto;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, rd, lfsr;
   logic [7:0]  hv, port;
   int          err_total, total_checks, n, b;

   sleep_wake_reset_control i_sleep_wake_reset_control
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .high_voltage_port(hv),
      .external_reset_pin_n(ext_n), .supply_low(sup), .wdt_fuse(fuse),
      .osc_select_high(osch), .osc_select_low(oscl), .wdt_timeout(wto),
      .core_reset_n(core_reset_n), .wdt_enable(wdt_enable), .sleeping(sleeping)
   );

   external_pins i_pins
   (
      .hclk(hclk), .high_voltage_port(hv), .external_reset_pin_n(ext_n), .supply_low(sup),
      .wdt_fuse(fuse), .osc_select_high(osch), .osc_select_low(oscl), .wdt_timeout(wto)
   );

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next

   // 25 ns clock period
   function automatic int cyc_of_us(input int us);
      return us * 1000 / 25;
   endfunction : cyc_of_us

   task automatic print_verdict;
      if (err_total == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Entered just after a rising edge; holds each phase until hready is seen high
   task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] q);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
      chk(32'(hresp), 32'h0);
   endtask : ahb

   // Start delay: a few cycles of slack allowed for sequencing
   task automatic check_start(input int us);
      int c;
      int e;
      c = 0;
      e = cyc_of_us(us);
      while (core_reset_n !== 1'b1 && c < 50000)
      begin
         @(posedge hclk);
         c++;
      end
      chk((c >= e && c <= e + 8) ? e : c, e);
   endtask : check_start

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   initial
   begin
      // Two short start delays plus bus traffic stay well inside this span
      #2_400_000;
      err_total++;
      print_verdict;
   end

   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 12'h000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      err_total = 0;
      total_checks = 0;
      lfsr = 32'h8a23;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      check_start(1000);
      ahb(1'b0, OFS_SECONDARY_OPTION_REGISTER, 32'h0, rd);
      chk(rd & 32'hff, {24'h0, SECONDARY_OPTION_REGISTER_RESET});
      ahb(1'b0, OFS_STATUS, 32'h0, rd);
      chk(32'(rd[BIT_PCW_FLAG]), 32'h1);
      chk(32'(wdt_enable), 32'h0);
      ahb(1'b0, 12'h0fc, 32'h0, rd);
      chk(rd, 32'h0);
      ahb(1'b1, OFS_SECONDARY_OPTION_REGISTER, 32'h12, rd);
      repeat (2) @(posedge hclk);
      chk(32'(wdt_enable), 32'h1);
      ahb(1'b1, OFS_SECONDARY_OPTION_REGISTER, 32'h02, rd);
      repeat (2) @(posedge hclk);
      chk(32'(wdt_enable), 32'h0);
      i_pins.set_ctl(1'b1, 1'b1);
      repeat (20) @(posedge hclk);
      chk(32'(wdt_enable), 32'h1);
      chk(32'(core_reset_n), 32'h1);
      // Sleep with random port levels as the wake references
      lfsr = lfsr_next(lfsr);
      port = lfsr[7:0];
      b = int'(lfsr[10:8]) % 5;
      b = (b == 4) ? WAKE_HI_PIN : b;
      i_pins.set_port(port);
      i_pins.set_ctl(1'b0, 1'b1);
      ahb(1'b1, OFS_SECONDARY_OPTION_REGISTER, 32'h03, rd);
      ahb(1'b1, OFS_CONTROL, 32'h01, rd);
      repeat (8) @(posedge hclk);
      chk(32'(sleeping), 32'h1);
      i_pins.set_ctl(1'b0, 1'b0);
      repeat (4) @(posedge hclk);
      chk(32'(wdt_enable), 32'h1);
      i_pins.set_port(port ^ (8'h01 << b));
      i_pins.set_port(port);
      for (int i = 0; i < 10; i++)
      begin
         lfsr = lfsr_next(lfsr);
         i_pins.set_port(port ^ {1'b0, lfsr[2:0], 4'h0});
      end
      i_pins.set_port(port);
      repeat (8) @(posedge hclk);
      chk(32'(sleeping), 32'h1);
      chk(32'(core_reset_n), 32'h1);
      i_pins.set_port(port ^ (8'h01 << b));
      n = 0;
      while (core_reset_n !== 1'b0 && n < 12)
      begin
         @(posedge hclk);
         n++;
      end
      chk(32'(core_reset_n), 32'h0);
      check_start(1000);
      chk(32'(sleeping), 32'h0);
      ahb(1'b0, OFS_STATUS, 32'h0, rd);
      chk(32'(rd[BIT_PCW_FLAG]), 32'h0);
      chk(rd, 32'h0);
      // Timeout ignored with the watchdog off, obeyed once the fuse enables it
      i_pins.set_wdt(1'b1);
      i_pins.set_wdt(1'b0);
      repeat (3) @(posedge hclk);
      chk(32'(core_reset_n), 32'h1);
      i_pins.set_ctl(1'b0, 1'b1);
      i_pins.set_wdt(1'b1);
      i_pins.set_wdt(1'b0);
      repeat (3) @(posedge hclk);
      chk(32'(core_reset_n), 32'h0);
      // Brown-out hold once detection is switched on
      ahb(1'b1, OFS_SECONDARY_OPTION_REGISTER, 32'h00, rd);
      i_pins.set_ctl(1'b1, 1'b0);
      repeat (8) @(posedge hclk);
      chk(32'(core_reset_n), 32'h0);
      repeat (50) @(posedge hclk);
      chk(32'(core_reset_n), 32'h0);
      i_pins.set_ctl(1'b0, 1'b0);
      repeat (10) @(posedge hclk);
      chk(32'(core_reset_n), 32'h0);
      print_verdict;
   end
endmodule : testbench
`default_nettype wire
